// [inc/rcc_pkg.sv]
package rcc_pkg;
    // =====================================================
    // register map
    localparam logic [3:0] ADDR_SECONDS = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h7;
    localparam logic [3:0] ADDR_CHG = 4'h8;
    localparam logic [3:0] ADDR_FLAG = 4'h9;
    localparam int CTRL_OUT_BIT = 7;
    localparam int CTRL_FT_BIT = 6;
    localparam int CTRL_SIGN_BIT = 5;
    localparam int CTRL_CAL_LSB = 0;
    localparam int SEC_OSC_DIS_BIT = 7;
    localparam int FLAG_OSF_BIT = 7;
    localparam int CHG_TCS_LSB = 4;
    localparam int CHG_DS_LSB = 2;
    localparam int CHG_RESISTOR_SELECT_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] CHG_RESET = 8'h00;
    localparam logic OSC_DIS_RESET = 1'h0;
    localparam logic OSF_RESET = 1'h1;
    localparam logic [3:0] CHG_UNLOCK = 4'ha;
    localparam logic [1:0] DS_NONE = 2'h1;
    localparam logic [1:0] DS_ONE = 2'h2;
    localparam logic [1:0] RESISTOR_SELECT_OFF = 2'h0;
    // =====================================================
    // divider chain and timing
    localparam logic [7:0] PRE_LAST = 8'hff;
    localparam logic [6:0] SUB_LAST = 7'h7f;
    localparam logic [5:0] SEC_LAST = 6'h3b;
    localparam logic [7:0] BLANK_CYCLES = 8'h80;
    localparam int TEST_TAP_BIT = 5;
    localparam int CLK_NS = 4;
    localparam int OSC_STOP_NS = 100000;
    localparam int OSC_STOP_CYC = (OSC_STOP_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {
        OSC_RUN = 2'h1,
        OSC_STOP = 2'h2
    } rcc_osc_state_t;
    function automatic logic rcc_charge_on(input logic [7:0] chg);
        logic [1:0] ds;
        ds = chg[CHG_DS_LSB+:2];
        return chg[CHG_TCS_LSB+:4] == CHG_UNLOCK && (ds == DS_NONE || ds == DS_ONE)
            && chg[CHG_RESISTOR_SELECT_LSB+:2] != RESISTOR_SELECT_OFF;
    endfunction
endpackage

// [design/rcc_cal_divider.sv]
module rcc_cal_divider import rcc_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic osc_tick,
    input wire logic div_clear,
    input wire logic cal_sign,
    input wire logic [4:0] cal_mag,
    output logic test_wave,
    output logic sec_tick
);
    typedef struct packed {
        logic [5:0] raw;
        logic [7:0] pre;
        logic [6:0] sub;
        logic [5:0] sec;
        logic [5:0] mins;
        logic [7:0] blank;
        logic tick;
    } rcc_div_state_t;
    rcc_div_state_t s, next_s;
    logic adjust;

    // =====================================================
    // chain: raw tap, /256 stage, /128 to seconds, minutes of the 64-minute cycle
    always_comb begin
        next_s = s;
        next_s.tick = 1'h0;
        // minute count wraps at 64 on its own; 2N never exceeds 62
        adjust = s.mins < {cal_mag, 1'h0};
        if (div_clear) begin
            next_s = '0;
        end else if (osc_tick) begin
            next_s.raw = s.raw + 6'h1;
            if (s.blank != 8'h0) begin
                next_s.blank = s.blank - 8'h1;
            end else begin
                next_s.pre = s.pre + 8'h1;
                if (s.pre == PRE_LAST) begin
                    next_s.sub = s.sub + 7'h1;
                    if (s.sub == SUB_LAST) begin
                        next_s.tick = 1'h1;
                        next_s.sec = (s.sec == SEC_LAST) ? 6'h0 : s.sec + 6'h1;
                        if (s.sec == SEC_LAST) begin
                            next_s.mins = s.mins + 6'h1;
                        end
                        // last second of a minute is the adjusted one
                        if (s.sec == SEC_LAST - 6'h1 && adjust) begin
                            if (cal_sign) begin
                                next_s.sub = 7'h1;
                            end else begin
                                next_s.blank = BLANK_CYCLES;
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign test_wave = s.raw[TEST_TAP_BIT];
    assign sec_tick = s.tick;

    property p_clear_chain;
        @(posedge clk) disable iff (reset)
        div_clear |=> s.pre == 8'h0 && s.sub == 7'h0 && s.blank == 8'h0 && s.raw == 6'h0;
    endproperty
    a_clear_chain: assert property (p_clear_chain) else $error("chain not cleared");
    property p_blank_holds;
        @(posedge clk) disable iff (reset)
        osc_tick && !div_clear && s.blank != 8'h0 |=> s.pre == $past(s.pre) && s.raw != $past(s.raw);
    endproperty
    a_blank_holds: assert property (p_blank_holds) else $error("blanking failed");
    property p_test_wave;
        @(posedge clk) disable iff (reset)
        osc_tick && !div_clear && s.raw == 6'h1f |=> test_wave != $past(test_wave);
    endproperty
    a_test_wave: assert property (p_test_wave) else $error("test tap wrong");
endmodule

// [design/rcc_top.sv]
module rcc_top import rcc_pkg::*; #(
    parameter int OSC_STOP_CYCLES = OSC_STOP_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic osc_clk_pin,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    output logic test_output_pin,
    output logic osc_enable,
    output logic charger_enable,
    output logic charger_diode,
    output logic [1:0] charger_res_sel,
    output logic sec_tick
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic [15:0] idle;
        rcc_osc_state_t osc;
        logic [7:0] ctrl;
        logic [7:0] chg;
        logic osc_dis;
        logic osc_stop_flag;
        logic [7:0] rdata;
        logic pin;
        logic oen;
        logic chg_en;
        logic diode;
        logic [1:0] res;
        logic sec;
        logic ctrl_written;
        logic chg_written;
    } rcc_top_state_t;
    rcc_top_state_t s, next_s;

    logic osc_edge;
    logic idle_out;
    logic wr_ctrl;
    logic wr_chg;
    logic wr_sec;
    logic wr_flag;
    logic stop_event;
    logic osc_tick;
    logic test_wave;
    logic div_sec;

    // =====================================================
    // divider chain with calibration
    rcc_cal_divider u_div (
        .clk(clk),
        .reset(reset),
        .osc_tick(osc_tick),
        .div_clear(wr_ctrl),
        .cal_sign(s.ctrl[CTRL_SIGN_BIT]),
        .cal_mag(s.ctrl[CTRL_CAL_LSB+:5]),
        .test_wave(test_wave),
        .sec_tick(div_sec)
    );

    // =====================================================
    // next state
    always_comb begin
        next_s = s;
        // two flops before anything looks at the oscillator pin
        next_s.sync1 = osc_clk_pin;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        osc_edge = s.sync2 && !s.sync3;
        idle_out = s.idle >= 16'(OSC_STOP_CYCLES);
        wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
        wr_chg = reg_wr && reg_addr == ADDR_CHG;
        wr_sec = reg_wr && reg_addr == ADDR_SECONDS;
        wr_flag = reg_wr && reg_addr == ADDR_FLAG;
        stop_event = 1'h0;
        osc_tick = 1'h0;

        // idle counter saturates so a long stall cannot wrap into a false run
        if (osc_edge) begin
            next_s.idle = 16'h0;
        end else if (!idle_out) begin
            next_s.idle = s.idle + 16'h1;
        end

        case (s.osc)
            OSC_RUN: begin
                osc_tick = osc_edge && !s.osc_dis;
                if (s.osc_dis || idle_out) begin
                    next_s.osc = OSC_STOP;
                    stop_event = 1'h1;
                end
            end
            OSC_STOP: begin
                if (!s.osc_dis && osc_edge) begin
                    next_s.osc = OSC_RUN;
                end
            end
            default: begin
                next_s.osc = OSC_STOP;
            end
        endcase

        if (wr_ctrl) begin
            next_s.ctrl = reg_wdata;
            next_s.ctrl_written = 1'h1;
        end
        if (wr_chg) begin
            next_s.chg = reg_wdata;
            next_s.chg_written = 1'h1;
        end
        if (wr_sec) begin
            next_s.osc_dis = reg_wdata[SEC_OSC_DIS_BIT];
        end
        // only a zero clears; the hardware set comes last and wins
        if (wr_flag && !reg_wdata[FLAG_OSF_BIT]) begin
            next_s.osc_stop_flag = 1'h0;
        end
        if (stop_event) begin
            next_s.osc_stop_flag = 1'h1;
        end

        case (reg_addr)
            ADDR_SECONDS: next_s.rdata = 8'(s.osc_dis) << SEC_OSC_DIS_BIT;
            ADDR_CTRL: next_s.rdata = s.ctrl;
            ADDR_CHG: next_s.rdata = s.chg;
            ADDR_FLAG: next_s.rdata = 8'(s.osc_stop_flag) << FLAG_OSF_BIT;
            default: next_s.rdata = 8'h0;
        endcase

        if (s.ctrl[CTRL_FT_BIT]) begin
            next_s.pin = test_wave;
        end else begin
            next_s.pin = s.ctrl[CTRL_OUT_BIT];
        end

        next_s.oen = !s.osc_dis;
        next_s.chg_en = rcc_charge_on(s.chg);
        next_s.diode = rcc_charge_on(s.chg) && s.chg[CHG_DS_LSB+:2] == DS_ONE;
        next_s.res = rcc_charge_on(s.chg) ? s.chg[CHG_RESISTOR_SELECT_LSB+:2] : RESISTOR_SELECT_OFF;
        next_s.sec = div_sec;
    end

    // =====================================================
    // state register; power-up values of the special registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.osc <= OSC_STOP;
            s.ctrl <= CTRL_RESET;
            s.chg <= CHG_RESET;
            s.osc_dis <= OSC_DIS_RESET;
            s.osc_stop_flag <= OSF_RESET;
            s.pin <= CTRL_RESET[CTRL_OUT_BIT];
            s.oen <= !OSC_DIS_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign test_output_pin = s.pin;
    assign osc_enable = s.oen;
    assign charger_enable = s.chg_en;
    assign charger_diode = s.diode;
    assign charger_res_sel = s.res;
    assign sec_tick = s.sec;

    // =====================================================
    // checks
    sequence s_run_to_stop;
        s.osc == OSC_RUN ##1 s.osc == OSC_STOP;
    endsequence

    sequence s_disable_write;
        wr_sec && reg_wdata[SEC_OSC_DIS_BIT] && s.osc == OSC_RUN;
    endsequence

    property p_level_out;
        @(posedge clk) disable iff (reset)
        !s.ctrl[CTRL_FT_BIT] |=> test_output_pin == $past(s.ctrl[CTRL_OUT_BIT]);
    endproperty
    a_level_out: assert property (p_level_out) else $error("pin ignores level bit");

    property p_test_out;
        @(posedge clk) disable iff (reset)
        s.ctrl[CTRL_FT_BIT] |=> test_output_pin == $past(test_wave);
    endproperty
    a_test_out: assert property (p_test_out) else $error("pin ignores test wave");

    property p_ctrl_powerup;
        @(posedge clk) disable iff (reset)
        !s.ctrl_written |-> s.ctrl == CTRL_RESET;
    endproperty
    a_ctrl_powerup: assert property (p_ctrl_powerup) else $error("control power-up value wrong");

    property p_chg_powerup;
        @(posedge clk) disable iff (reset)
        !s.chg_written |-> s.chg == CHG_RESET && !charger_enable;
    endproperty
    a_chg_powerup: assert property (p_chg_powerup) else $error("charger power-up value wrong");

    property p_charger;
        @(posedge clk) disable iff (reset)
        ##1 charger_enable == rcc_charge_on($past(s.chg))
            && charger_res_sel == (charger_enable ? $past(s.chg[CHG_RESISTOR_SELECT_LSB+:2]) : RESISTOR_SELECT_OFF);
    endproperty
    a_charger: assert property (p_charger) else $error("charger decode wrong");

    property p_stop_sets;
        @(posedge clk) disable iff (reset)
        s_run_to_stop |-> s.osc_stop_flag;
    endproperty
    a_stop_sets: assert property (p_stop_sets) else $error("stop flag not set");

    property p_disable_sets;
        @(posedge clk) disable iff (reset)
        s_disable_write |-> ##[2:3] s.osc_stop_flag && s.osc == OSC_STOP;
    endproperty
    a_disable_sets: assert property (p_disable_sets) else $error("disable did not stop");

    property p_flag_sticky;
        @(posedge clk) disable iff (reset)
        s.osc_stop_flag && !(wr_flag && !reg_wdata[FLAG_OSF_BIT]) |=> s.osc_stop_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("stop flag lost");

    property p_flag_low_bits;
        @(posedge clk) disable iff (reset)
        reg_addr == ADDR_FLAG |=> reg_rdata[6:0] == 7'h0 && reg_rdata[FLAG_OSF_BIT] == $past(s.osc_stop_flag);
    endproperty
    a_flag_low_bits: assert property (p_flag_low_bits) else $error("flag readback wrong");

    property p_ctrl_clears_div;
        @(posedge clk) disable iff (reset)
        wr_ctrl |=> s.ctrl == $past(reg_wdata) ##1 !sec_tick;
    endproperty
    a_ctrl_clears_div: assert property (p_ctrl_clears_div) else $error("control write not applied");

    property p_no_tick_stopped;
        @(posedge clk) disable iff (reset)
        s.osc == OSC_STOP |-> !osc_tick;
    endproperty
    a_no_tick_stopped: assert property (p_no_tick_stopped) else $error("chain runs while stopped");
endmodule

// [bench/rcc_osc_model.sv]
// =====================================================
// 32 kHz oscillator stand-in, 80 ns period while running
module rcc_osc_model (
    input wire logic run,
    output logic osc_clk_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        osc_clk_pin = 1'b0;
        // start delay does not shift the always block; its edges fall on the system clock grid
        #1;
    end
    // a stopped crystal stands still low, it does not park high
    always begin
        if (run) begin
            #40 osc_clk_pin = 1'b1;
            #40 osc_clk_pin = 1'b0;
        end else begin
            #40;
        end
    end
endmodule

// [bench/rcc_top_bench.sv]
module rcc_top_bench import rcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, osc_run, osc_clk_pin, reg_wr;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic test_output_pin, osc_enable, charger_enable, charger_diode, sec_tick;
    logic [1:0] charger_res_sel;
    logic [7:0] mdl [16];
    logic [7:0] cfg [3] = '{8'h40, 8'h7f, 8'h5f};
    int miscompares, num_checks, seed, n, i;

    rcc_osc_model osc (.run(osc_run), .osc_clk_pin(osc_clk_pin));
    rcc_top #(.OSC_STOP_CYCLES(100)) DUT (.clk(clk), .reset(reset), .osc_clk_pin(osc_clk_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .test_output_pin(test_output_pin), .osc_enable(osc_enable), .charger_enable(charger_enable),
        .charger_diode(charger_diode), .charger_res_sel(charger_res_sel), .sec_tick(sec_tick));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // =====================================================
    // reference model and helpers
    function automatic logic chg_on(input logic [7:0] v);
        return v[7:4] == 4'ha && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && v[1:0] != 2'h0;
    endfunction

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // model keeps only what the register rules allow to be stored
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        case (a)
            ADDR_SECONDS: mdl[0] = {v[7], 7'h0};
            ADDR_CTRL, ADDR_CHG: mdl[a] = v;
            ADDR_FLAG: if (!v[7]) mdl[9] = 8'h00;
            default: ;
        endcase
    endtask

    task automatic rd(input logic [3:0] a, input string nm);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        @(posedge clk);
        #1 check(nm, reg_rdata, mdl[a]);
    endtask

    // counts oscillator rises until the pin reaches lvl; bounded
    task automatic wait_pin(input logic lvl, output int cnt);
        logic prev;
        int k;
        cnt = 0;
        prev = osc_clk_pin;
        for (k = 0; k < 3000 && test_output_pin !== lvl; k++) begin
            @(posedge clk);
            #1;
            if (osc_clk_pin && !prev) cnt++;
            prev = osc_clk_pin;
        end
        if (k >= 3000) begin
            miscompares++;
            $display("[FAIL] test pin never reached %b", lvl);
            complete_run();
        end
    endtask

    // =====================================================
    // main sequence
    initial begin
        seed = 94296;
        reset = 1'b1;
        osc_run = 1'b1;
        reg_wr = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        foreach (mdl[k]) mdl[k] = 8'h00;
        mdl[7] = 8'h80;
        mdl[9] = 8'h80;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1 check("pin_reset", 8'(test_output_pin), 8'h01);
        check("chg_reset", 8'(charger_enable), 8'h00);
        check("osc_en_reset", 8'(osc_enable), 8'h01);
        rd(ADDR_CTRL, "ctrl_reset");
        rd(ADDR_CHG, "chg_reg_reset");
        rd(ADDR_FLAG, "flag_reset");
        wr(4'h5, 8'h5a);
        rd(4'h5, "unmapped");
        repeat (20) @(posedge clk);
        wr(ADDR_FLAG, 8'hff);
        rd(ADDR_FLAG, "flag_write1");
        wr(ADDR_FLAG, 8'h7f);
        rd(ADDR_FLAG, "flag_clear");
        for (i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            if (i[0]) d[7:4] = 4'ha;
            if (i[1]) d[3:2] = i[2] ? 2'h1 : 2'h2;
            d[1:0] = i[3:2];
            wr(ADDR_CHG, d);
            repeat (3) @(posedge clk);
            check("chg_en", 8'(charger_enable), 8'(chg_on(d)));
            check("chg_diode", 8'(charger_diode), 8'(chg_on(d) && d[3:2] == 2'h2));
            check("chg_res", 8'(charger_res_sel), 8'(chg_on(d) ? d[1:0] : 2'h0));
            rd(ADDR_CHG, "chg_reg");
        end
        wr(ADDR_CTRL, 8'h3f);
        repeat (3) @(posedge clk);
        check("pin_low", 8'(test_output_pin), 8'h00);
        check("sec_tick_idle", 8'(sec_tick), 8'h00);
        rd(ADDR_CTRL, "ctrl_all_cal");
        wr(ADDR_CTRL, 8'h80);
        repeat (3) @(posedge clk);
        check("pin_high", 8'(test_output_pin), 8'h01);
        // each setting: write lands mid oscillator period, chain restarts
        for (i = 0; i < 3; i++) begin
            @(posedge osc_clk_pin);
            repeat (8) @(posedge clk);
            wr(ADDR_CTRL, cfg[i]);
            // the pin lags the control register by one edge; start counting once it shows the cleared tap
            repeat (2) @(posedge clk);
            wait_pin(1'b1, n);
            check("first_half", 8'(n), 8'd32);
            wait_pin(1'b0, n);
            check("half_period", 8'(n), 8'd32);
            wait_pin(1'b1, n);
            check("next_half", 8'(n), 8'd32);
        end
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_FLAG, 8'h00);
        osc_run <= 1'b0;
        repeat (150) @(posedge clk);
        mdl[9] = 8'h80;
        rd(ADDR_FLAG, "flag_on_stop");
        wr(ADDR_FLAG, 8'h00);
        rd(ADDR_FLAG, "flag_cleared");
        osc_run <= 1'b1;
        repeat (100) @(posedge clk);
        wr(ADDR_SECONDS, 8'hff);
        mdl[9] = 8'h80;
        repeat (3) @(posedge clk);
        check("osc_off", 8'(osc_enable), 8'h00);
        rd(ADDR_FLAG, "flag_on_disable");
        rd(ADDR_SECONDS, "seconds_bit7");
        wr(ADDR_SECONDS, 8'h00);
        repeat (3) @(posedge clk);
        check("osc_on", 8'(osc_enable), 8'h01);
        complete_run();
    end
endmodule
